/* design/vtl_lookup.sv */
/*
 * Input selector, lookup controller and translation table, one cell per cell time,
 * with a classic Wishbone slave for settings and status.
 * Assumes queues, rebuilder and cell store run on mclk and keep their own handshakes.
 */
// Functional notes
// [RULE_01] Selector takes at most one cell per cell time, forwarded unchanged.
// [RULE_02] Non-idle recirculation code wins; otherwise the link queue cell goes on.
// [RULE_03] On rebuilder grant send ready cell and pointer, else an idle code.
// [RULE_04] Grant to recirculation queue whenever a slot is free.
// [RULE_05] Data cell path uses low 8 bits, checked against 0..path count.
// [RULE_06] Path entry with path_terminates 0 passes circuit unchecked, one read only.
// [RULE_07] Terminating path: circuit in 0..1022-count reads entry 1023-circuit.
// [RULE_08] Fresh data cell hitting recirc_only entry is dropped silently.
// [RULE_09] In-use entry, allowed cell: counter incremented and written alone.
// [RULE_10] Continuous stream cells kept; others dropped while hold timer non-zero.
// [RULE_11] Congestion loads hold timer; it counts down per cell time to zero.
// [RULE_12] Each congestion drop pulses the discard counter increment.
// [RULE_13] Outgoing loss priority is incoming OR force_loss_priority.
// [RULE_14] Entry minus force_loss_priority and path_terminates bits and counter goes out; non-terminating path keeps circuit.
// [RULE_15] Plain recirculated control cells pass unchanged.
// [RULE_16] Table ops check selected identifier; failure returns bad-field, cell kept.
// [RULE_17] Writes store info, then entry read back with time and success.
// [RULE_18] Every handled cell delivers its cell store pointer; the code delivers none for dropped cells.
// [RULE_19] Table of 1024 entries, paths low, circuits from the top.
// [RULE_20] Counter has its own write, apart from the 14-byte fields.
// [RULE_21] At most four table accesses per cell.
// [RULE_22] Reset clears in-use and counter of every entry.
// [RULE_23] Data cell on unused entry dropped, not counted, not forwarded.
`default_nettype none
module vtl_lookup #(
   parameter int CELL_CYCLES = vtl_pkg::CELL_CYC
) (
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire vtl_pkg::vtl_cell_t  rxCell,
   input  wire vtl_pkg::vtl_cell_t  recircCell,
   input  wire logic                rxCongestion,
   input  wire logic                rebuilderGrant,
   output var  logic                recircGrant,
   output var  vtl_pkg::vtl_out_t   rebuildCell,
   output var  logic [15:0]         cellStorePtr,
   output var  logic                cellStorePtrValid,
   output var  logic                discardInc,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output var  logic [31:0]         wb_dat_o,
   output var  logic                wb_ack_o
);
   import vtl_pkg::*;

   function automatic logic isOp(input logic [4:0] c);
      return (c >= OP_FIRST) && (c <= OP_LAST);
   endfunction

   function automatic logic [9:0] circIndex(input logic [15:0] vci);
      return TOP_IDX - vci[9:0];
   endfunction

   function automatic logic circOk(input logic [15:0] vci, input logic [7:0] pc);
      return vci <= {6'h00, CIRC_MAX - {2'b00, pc}};
   endfunction

   // ***************************************************************
   // Cell time, settings and status
   // ***************************************************************
   logic [7:0]  cellCnt_r;
   logic        cellTick_r;
   logic [7:0]  pathCount_r;
   logic [15:0] hold_r;
   logic [15:0] holdTimer_r;
   logic        rangeFlag_r;
   logic [27:0] rangeHdr_r;
   logic [31:0] discards_r;
   logic [31:0] time_r;
   logic        setRange;
   logic        dropCong;
   logic        wbWr;
   vtl_cell_t   cur_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cellCnt_r <= 8'h00;
         cellTick_r <= 1'b0;
         time_r <= 32'h0000_0000;
      end else begin
         cellTick_r <= (cellCnt_r == 8'(CELL_CYCLES - 1));
         cellCnt_r <= (cellCnt_r == 8'(CELL_CYCLES - 1)) ? 8'h00 : cellCnt_r + 8'h01;
         if (cellTick_r) begin
            time_r <= time_r + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         holdTimer_r <= 16'h0000;
      end else if (rxCongestion) begin
         holdTimer_r <= hold_r; // see [RULE_11]
      end else if (cellTick_r && holdTimer_r != 16'h0000) begin
         holdTimer_r <= holdTimer_r - 16'h0001; // see [RULE_11]
      end
   end

   assign wbWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pathCount_r <= PATH_COUNT_RST;
         hold_r <= HOLD_RST;
      end else if (wbWr) begin
         if (wb_adr_i == A_PATH_COUNT && wb_sel_i[0]) begin
            pathCount_r <= wb_dat_i[7:0];
         end
         if (wb_adr_i == A_HOLD) begin
            if (wb_sel_i[0]) begin
               hold_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               hold_r[15:8] <= wb_dat_i[15:8];
            end
         end
      end
   end

   // The flag is write-one-to-clear; a new violation in the same cycle wins.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rangeFlag_r <= 1'b0;
         rangeHdr_r <= 28'h0000000;
         discards_r <= 32'h0000_0000;
         discardInc <= 1'b0;
      end else begin
         discardInc <= dropCong; // see [RULE_12]
         if (dropCong) begin
            discards_r <= discards_r + 32'h0000_0001;
         end
         if (setRange) begin
            rangeFlag_r <= 1'b1; // see [RULE_05]
            rangeHdr_r <= {cur_r.vpi, cur_r.vci};
         end else if (wbWr && wb_adr_i == A_STATUS && wb_sel_i[0] && wb_dat_i[0]) begin
            rangeFlag_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         case (wb_adr_i)
            A_PATH_COUNT: wb_dat_o <= {24'h000000, pathCount_r};
            A_HOLD: wb_dat_o <= {16'h0000, hold_r};
            A_STATUS: wb_dat_o <= {31'h00000000, rangeFlag_r};
            A_RANGE_HDR: wb_dat_o <= {4'h0, rangeHdr_r};
            A_DISCARDS: wb_dat_o <= discards_r;
            A_TIME: wb_dat_o <= time_r;
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************************
   // Translation table
   // ***************************************************************
   logic [110:0] infoMem [DEPTH];
   logic         inUse_r [DEPTH];
   logic [15:0]  cntMem [DEPTH];
   logic [9:0]   idx_r;
   logic [111:0] rdInfo;
   logic         wrInfo;
   logic         wrCnt;
   logic [15:0]  wrCntVal;

   assign rdInfo = {inUse_r[idx_r], infoMem[idx_r]};

   always_ff @(posedge mclk) begin
      if (wrInfo) begin
         infoMem[idx_r] <= cur_r.info[126:16]; // see [RULE_17]
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            inUse_r[i] <= 1'b0; // see [RULE_22]
            cntMem[i] <= 16'h0000;
         end
      end else begin
         if (wrInfo) begin
            inUse_r[idx_r] <= cur_r.info[127];
         end
         if (wrCnt) begin
            cntMem[idx_r] <= wrCntVal; // see [RULE_20]
         end
      end
   end

   // ***************************************************************
   // Selector and lookup controller
   // ***************************************************************
   vtl_state_t   state_r;
   logic         viaCircuit_r;
   logic [111:0] entry_r;
   logic [15:0]  entryCnt_r;
   vtl_out_t     res_r;
   logic         resReady_r;
   logic         isData;
   logic         pathOk;
   logic         room;
   logic         counted;
   logic         keepData;
   logic [127:0] dataInfo;

   assign isData = cur_r.code == CC_FRESH_DATA || cur_r.code == CC_RECIRC_DATA;
   assign pathOk = {4'h0, cur_r.vpi[7:0]} <= {4'h0, pathCount_r}; // see [RULE_05]
   assign room = state_r == S_IDLE && !resReady_r;
   assign counted = entry_r[F_IN_USE]
                    && (!entry_r[F_RECIRC_ONLY] || cur_r.code == CC_RECIRC_DATA); // see [RULE_09]
   assign keepData = counted && (cur_r.info[0] || holdTimer_r == 16'h0000); // see [RULE_10]
   assign dropCong = state_r == S_EVAL && counted && !keepData; // see [RULE_12]
   assign setRange = (state_r == S_CHECK && isData && !pathOk)
                     || (state_r == S_RDP && rdInfo[F_PATH_TERM]
                         && !circOk(cur_r.vci, pathCount_r));
   assign wrInfo = state_r == S_WRITE;
   assign wrCnt = (state_r == S_WRITE && cur_r.code[1:0] == 2'b11)
                  || (state_r == S_EVAL && counted);
   assign wrCntVal = state_r == S_WRITE ? cur_r.info[15:0] : entryCnt_r + 16'h0001;

   always_comb begin
      dataInfo = {entry_r, 16'h0000}; // see [RULE_14]
      dataInfo[F_FORCE_LP + 16] = 1'b0;
      dataInfo[F_PATH_TERM + 16] = 1'b0;
      // The circuit entry's own terminate bit means nothing; the path entry decides.
      if (!viaCircuit_r) begin
         dataInfo[F_ID1_VCI + 16 +: 16] = cur_r.vci;
         dataInfo[F_ID2_VCI + 16 +: 16] = cur_r.vci;
      end
   end

   // Data cell bit 0 of the info carries the continuous-stream flag.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
         cur_r <= '0;
         idx_r <= 10'h000;
         entry_r <= '0;
         viaCircuit_r <= 1'b0;
         entryCnt_r <= 16'h0000;
         res_r <= '0;
         resReady_r <= 1'b0;
         recircGrant <= 1'b0;
         rebuildCell <= '0;
         cellStorePtr <= 16'h0000;
         cellStorePtrValid <= 1'b0;
      end else begin
         recircGrant <= room; // see [RULE_04]
         cellStorePtrValid <= 1'b0;
         if (cellTick_r) begin
            rebuildCell <= '0;
            rebuildCell.code <= CC_IDLE; // see [RULE_03]
            if (rebuilderGrant && resReady_r) begin
               rebuildCell <= res_r;
               cellStorePtr <= cur_r.ptr; // see [RULE_18]
               cellStorePtrValid <= 1'b1;
               resReady_r <= 1'b0;
            end
         end
         case (state_r)
            S_IDLE: begin
               if (cellTick_r && room) begin
                  if (recircCell.code != CC_IDLE) begin
                     cur_r <= recircCell; // see [RULE_02]
                     state_r <= S_CHECK;
                  end else if (rxCell.code != CC_IDLE) begin
                     cur_r <= rxCell; // see [RULE_01]
                     state_r <= S_CHECK;
                  end
               end
            end
            S_CHECK: begin
               res_r <= '0;
               res_r.code <= cur_r.code;
               res_r.vpi <= cur_r.vpi;
               res_r.vci <= cur_r.vci;
               res_r.clp <= cur_r.clp;
               res_r.info <= cur_r.info;
               res_r.localTime <= time_r;
               if (isData) begin
                  idx_r <= {2'b00, cur_r.vpi[7:0]}; // see [RULE_19]
                  state_r <= pathOk ? S_RDP : S_IDLE;
               end else if (isOp(cur_r.code)) begin
                  if (cur_r.code[0] ? pathOk : circOk(cur_r.vci, pathCount_r)) begin
                     idx_r <= cur_r.code[0] ? {2'b00, cur_r.vpi[7:0]}
                                            : circIndex(cur_r.vci); // see [RULE_16]
                     state_r <= cur_r.code >= OP_FIRST_WR ? S_WRITE : S_READ;
                  end else begin
                     res_r.returnValue <= RV_BAD_FIELD; // see [RULE_16]
                     resReady_r <= 1'b1;
                     state_r <= S_IDLE;
                  end
               end else begin
                  resReady_r <= 1'b1; // see [RULE_15]
                  state_r <= S_IDLE;
               end
            end
            S_RDP: begin
               entry_r <= rdInfo;
               viaCircuit_r <= rdInfo[F_PATH_TERM]; // see [RULE_14]
               entryCnt_r <= cntMem[idx_r];
               if (!rdInfo[F_PATH_TERM]) begin
                  state_r <= S_EVAL; // see [RULE_06]
               end else if (circOk(cur_r.vci, pathCount_r)) begin
                  idx_r <= circIndex(cur_r.vci); // see [RULE_07]
                  state_r <= S_RDC;
               end else begin
                  state_r <= S_IDLE;
               end
            end
            S_RDC: begin
               entry_r <= rdInfo;
               entryCnt_r <= cntMem[idx_r];
               state_r <= S_EVAL;
            end
            S_EVAL: begin
               res_r.clp <= cur_r.clp | entry_r[F_FORCE_LP]; // see [RULE_13]
               res_r.info <= dataInfo;
               resReady_r <= keepData; // see [RULE_08] [RULE_23]
               state_r <= S_IDLE;
            end
            S_WRITE: begin
               state_r <= S_READ;
            end
            S_READ: begin
               res_r.info <= {rdInfo, cntMem[idx_r]}; // see [RULE_17]
               res_r.returnValue <= RV_SUCCESS;
               resReady_r <= 1'b1;
               state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   int accesses_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         accesses_r <= 0;
      end else if (state_r == S_CHECK) begin
         accesses_r <= 0;
      end else if (state_r inside {S_RDP, S_RDC, S_WRITE, S_READ} || wrCnt) begin
         accesses_r <= accesses_r + 1;
      end
   end

   sequence accept_s;
      state_r == S_IDLE && cellTick_r && room && recircCell.code != CC_IDLE;
   endsequence

   table_budget_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_21]
      accesses_r <= 4) else $error("more than four table accesses in one cell");
   recirc_first_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_02]
      accept_s |=> cur_r == $past(recircCell)) else $error("recirculated cell not chosen");
   grant_room_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_04]
      $past(rst_n) |-> recircGrant == $past(room)) else $error("recirculation grant wrong");
   idle_out_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_03]
      cellTick_r && !(rebuilderGrant && resReady_r) |=> rebuildCell.code == CC_IDLE)
      else $error("idle code missing");
   ptr_pair_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_18]
      cellStorePtrValid |-> rebuildCell.code != CC_IDLE) else $error("pointer without cell");
   hold_load_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_11]
      rxCongestion |=> holdTimer_r == $past(hold_r)) else $error("hold timer not loaded");
   cong_drop_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_10]
      state_r == S_EVAL && holdTimer_r != 16'h0000 && !cur_r.info[0] |=> !resReady_r)
      else $error("low priority cell kept under congestion");
   cong_count_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_12]
      dropCong |=> discardInc && discards_r == $past(discards_r) + 32'h0000_0001)
      else $error("congestion drop not counted");
   range_flag_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_05]
      state_r == S_CHECK && isData && !pathOk |=> rangeFlag_r && state_r == S_IDLE)
      else $error("out of range path not flagged");
   counter_inc_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_09]
      state_r == S_EVAL && counted |=> cntMem[$past(idx_r)] == $past(entryCnt_r) + 16'h0001)
      else $error("cell counter not incremented");
   clp_or_a: assert property (@(posedge mclk) disable iff (!rst_n) // see [RULE_13]
      state_r == S_EVAL |=> res_r.clp == ($past(cur_r.clp) | $past(entry_r[F_FORCE_LP])))
      else $error("loss priority wrong");
endmodule
`default_nettype wire

/* inc/vtl_pkg.sv */
/*
 * Shared constants and carriers for the circuit translation lookup.
 * Assumes one 50 MHz clock and same-clock neighbouring queues.
 */
`default_nettype none
package vtl_pkg;
   localparam int CLK_MHZ = 50;
   localparam int CELL_NS = 160;
   localparam int CELL_CYC = CELL_NS * CLK_MHZ / 1000;
   localparam int DEPTH = 1024;
   localparam logic [9:0] TOP_IDX = 10'h3FF;
   localparam logic [9:0] CIRC_MAX = 10'h3FE;
   // Cell codes; table operations occupy 3 to 12.
   localparam logic [4:0] CC_IDLE = 5'h10;
   localparam logic [4:0] CC_FRESH_DATA = 5'h11;
   localparam logic [4:0] CC_FRESH_CTL = 5'h12;
   localparam logic [4:0] CC_RECIRC_DATA = 5'h13;
   localparam logic [4:0] CC_RECIRC_CTL = 5'h14;
   localparam logic [4:0] OP_FIRST = 5'h03;
   localparam logic [4:0] OP_LAST = 5'h0C;
   localparam logic [4:0] OP_FIRST_WR = 5'h05;
   localparam logic [3:0] RV_SUCCESS = 4'h0;
   localparam logic [3:0] RV_BAD_FIELD = 4'h2;
   // Entry field positions inside the 112-bit information part.
   localparam int F_IN_USE = 111;
   localparam int F_RECIRC_ONLY = 110;
   localparam int F_FORCE_LP = 109;
   localparam int F_PATH_TERM = 108;
   localparam int F_ID1_VCI = 84;
   localparam int F_ID2_VCI = 60;
   // Wishbone byte addresses.
   localparam logic [7:0] A_PATH_COUNT = 8'h00;
   localparam logic [7:0] A_HOLD = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_RANGE_HDR = 8'h0C;
   localparam logic [7:0] A_DISCARDS = 8'h10;
   localparam logic [7:0] A_TIME = 8'h14;
   localparam logic [7:0] PATH_COUNT_RST = 8'h7F;
   localparam logic [15:0] HOLD_RST = 16'h0010;

   typedef struct packed {
      logic [4:0] code;
      logic [11:0] vpi;
      logic [15:0] vci;
      logic clp;
      logic [15:0] ptr;
      logic [127:0] info;
   } vtl_cell_t;

   typedef struct packed {
      logic [4:0] code;
      logic [11:0] vpi;
      logic [15:0] vci;
      logic clp;
      logic [127:0] info;
      logic [31:0] localTime;
      logic [3:0] returnValue;
   } vtl_out_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_CHECK = 3'b001, S_RDP = 3'b010,
      S_RDC = 3'b011, S_EVAL = 3'b100, S_WRITE = 3'b101, S_READ = 3'b110
   } vtl_state_t;
endpackage
`default_nettype wire

/* dv/vtl_far_side.sv */
/*
 * Far-side model: recirculation and link queues feeding the selector, plus the rebuilder grant.
 * Assumes the bench raises go for one cycle with the cell to send standing in offer.
 */
`default_nettype none
module vtl_far_side (
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               recircGrant,
   input  wire logic               go,
   input  wire logic               fromRx,
   input  wire logic               stall,
   input  wire vtl_pkg::vtl_cell_t offer,
   output var  vtl_pkg::vtl_cell_t rxCell,
   output var  vtl_pkg::vtl_cell_t recircCell,
   output var  logic               rebuilderGrant,
   output var  logic               taken
);
   timeunit 1ns;
   timeprecision 1ps;
   import vtl_pkg::*;
   logic      pend_r, seen_r, rx_r;
   vtl_cell_t cell_r, idleCell;
   // A cell counts as taken once the slot grant falls after it was seen high.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
         seen_r <= 1'b0;
         rx_r <= 1'b0;
         taken <= 1'b0;
         cell_r <= '0;
      end else begin
         taken <= 1'b0;
         if (go) begin
            pend_r <= 1'b1;
            seen_r <= 1'b0;
            cell_r <= offer;
            rx_r <= fromRx;
         end else if (pend_r && recircGrant) begin
            seen_r <= 1'b1;
         end else if (pend_r && seen_r) begin
            pend_r <= 1'b0;
            taken <= 1'b1;
         end
      end
   end
   // Idle lines carry the inverse of the last cell so stale fields never look valid.
   always_comb begin
      idleCell = ~cell_r;
      idleCell.code = CC_IDLE;
      rxCell = (pend_r && rx_r) ? cell_r : idleCell;
      recircCell = (pend_r && !rx_r) ? cell_r : idleCell;
   end
   assign rebuilderGrant = !stall;
endmodule
`default_nettype wire

/* dv/tb_vtl_lookup.sv */
/*
 * Bench for vtl_lookup: table access cells, lookups, drops, congestion and bus registers.
 * Assumes vtl_far_side stands in for both queues and the rebuilder.
 */
`default_nettype none
module tb_vtl_lookup;
   timeunit 1ns;
   timeprecision 1ps;
   import vtl_pkg::*;
   localparam logic [111:0] EA = 112'hA0AB_CDEF_0123_4567_89AB_CDEF_0123;
   localparam logic [111:0] EP = 112'h9000_0000_0000_0000_0000_0000_0001;
   localparam logic [111:0] EC = 112'hC555_0000_1111_2222_3333_4444_5555;
   logic mclk, rst_n, rxCongestion, go, fromRx, stall, recircGrant, rebuilderGrant, taken;
   logic cellStorePtrValid, discardInc, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]   wb_adr_i;
   logic [3:0]   wb_sel_i;
   logic [31:0]  wb_dat_i, wb_dat_o;
   logic [15:0]  cellStorePtr;
   logic [127:0] di;
   vtl_cell_t    offer, rxCell, recircCell, c;
   vtl_out_t     rebuildCell, got;
   int           err_total, total_checks, cycles, discSeen;
   vtl_lookup #(.CELL_CYCLES(8)) uut (.mclk(mclk), .rst_n(rst_n), .rxCell(rxCell),
      .recircCell(recircCell), .rxCongestion(rxCongestion), .rebuilderGrant(rebuilderGrant),
      .recircGrant(recircGrant), .rebuildCell(rebuildCell), .cellStorePtr(cellStorePtr),
      .cellStorePtrValid(cellStorePtrValid), .discardInc(discardInc), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   vtl_far_side far (.mclk(mclk), .rst_n(rst_n), .recircGrant(recircGrant), .go(go),
      .fromRx(fromRx), .stall(stall), .offer(offer), .rxCell(rxCell),
      .recircCell(recircCell), .rebuilderGrant(rebuilderGrant), .taken(taken));
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (discardInc === 1'b1) discSeen++;
      if (cycles > 30000) begin
         err_total++;
         close_out();
      end
   end
   // ****************************************
   // Checks and transfer tasks
   // ****************************************
   task automatic close_out;
      if (err_total == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [255:0] g, input logic [255:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   function automatic vtl_out_t ex(vtl_cell_t k, logic cl, logic [127:0] inf, logic [3:0] rv);
      return vtl_out_t'{k.code, k.vpi, k.vci, cl, inf, 32'h0, rv};
   endfunction
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (!we) chk(wb_dat_o, e);
      if (n >= 50) err_total++;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge mclk);
   endtask
   // Mode 0 expects a drop, 1 a full compare, 2 delivery only.
   task automatic xfer(input vtl_cell_t k, input logic rx, input logic [1:0] m, input vtl_out_t e);
      int n;
      n = 0;
      offer <= k;
      fromRx <= rx;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      while (taken !== 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      n = 0;
      while (cellStorePtrValid !== 1'b1 && n < 48) begin
         @(posedge mclk);
         n++;
      end
      chk(n < 48, m != 2'd0);
      got = rebuildCell;
      got.localTime = '0;
      if (m == 2'd1) chk(got, e);
      if (m != 2'd0) begin
         chk(cellStorePtr, k.ptr);
         repeat (10) @(posedge mclk);
         chk(rebuildCell.code, CC_IDLE);
      end
   endtask
   initial begin
      {mclk, rst_n, rxCongestion, go, fromRx, stall, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
      {wb_adr_i, wb_dat_i, offer, err_total, total_checks, cycles, discSeen} = '0;
      wb_sel_i = 4'hF;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      wb(1'b0, A_PATH_COUNT, 32'h0, 32'h7F);
      wb(1'b0, A_HOLD, 32'h0, 32'h10);
      wb(1'b0, 8'h3C, 32'h0, 32'h0);
      c = vtl_cell_t'{CC_FRESH_DATA, 12'h005, 16'h0, 1'b0, 16'h0101, 128'h1};
      xfer(c, 1'b1, 2'd0, got);
      c = vtl_cell_t'{OP_FIRST, 12'h005, 16'h0, 1'b0, 16'h0102, 128'h0};
      xfer(c, 1'b0, 2'd2, got);
      chk({got.info[127], got.info[15:0], got.returnValue}, {17'h0, RV_SUCCESS});
      c = vtl_cell_t'{5'h07, 12'h002, 16'h0, 1'b0, 16'h0201, {EA, 16'h0005}};
      xfer(c, 1'b0, 2'd1, ex(c, 1'b0, c.info, RV_SUCCESS));
      di = {EA, 16'h0};
      di[125:124] = 2'b00;
      di[115:100] = 16'h1234;
      di[91:76] = 16'h1234;
      c = vtl_cell_t'{CC_FRESH_DATA, 12'h302, 16'h1234, 1'b0, 16'h0202, 128'h1};
      xfer(c, 1'b1, 2'd1, ex(c, 1'b1, di, RV_SUCCESS));
      c = vtl_cell_t'{OP_FIRST, 12'h002, 16'h0, 1'b0, 16'h0203, 128'h0};
      xfer(c, 1'b0, 2'd1, ex(c, 1'b0, {EA, 16'h0006}, RV_SUCCESS));
      c = vtl_cell_t'{OP_FIRST_WR, 12'h003, 16'h0, 1'b0, 16'h0301, {EP, 16'h0}};
      xfer(c, 1'b0, 2'd1, ex(c, 1'b0, c.info, RV_SUCCESS));
      c = vtl_cell_t'{5'h06, 12'h0, 16'h037F, 1'b0, 16'h0302, {EC, 16'h0}};
      xfer(c, 1'b0, 2'd1, ex(c, 1'b0, c.info, RV_SUCCESS));
      c = vtl_cell_t'{CC_FRESH_DATA, 12'h003, 16'h037F, 1'b1, 16'h0303, 128'h1};
      xfer(c, 1'b1, 2'd0, got);
      c.code = CC_RECIRC_DATA;
      xfer(c, 1'b0, 2'd1, ex(c, 1'b1, {EC, 16'h0}, RV_SUCCESS));
      c = vtl_cell_t'{5'h04, 12'h0, 16'h037F, 1'b0, 16'h0304, 128'h0};
      xfer(c, 1'b0, 2'd1, ex(c, 1'b0, {EC, 16'h0001}, RV_SUCCESS));
      c = vtl_cell_t'{CC_RECIRC_DATA, 12'h003, 16'h0380, 1'b0, 16'h0305, 128'h1};
      xfer(c, 1'b0, 2'd0, got);
      wb(1'b0, A_STATUS, 32'h0, 32'h1);
      wb(1'b0, A_RANGE_HDR, 32'h0, {4'h0, 12'h003, 16'h0380});
      wb(1'b1, A_STATUS, 32'h1, 32'h0);
      wb(1'b0, A_STATUS, 32'h0, 32'h0);
      c = vtl_cell_t'{5'h04, 12'h0, 16'h0380, 1'b0, 16'h0306, 128'h0};
      xfer(c, 1'b0, 2'd2, got);
      chk({got.code, got.returnValue}, {5'h04, RV_BAD_FIELD});
      c = vtl_cell_t'{OP_FIRST, 12'h080, 16'h0, 1'b0, 16'h0307, 128'h0};
      xfer(c, 1'b0, 2'd2, got);
      chk({got.code, got.returnValue}, {OP_FIRST, RV_BAD_FIELD});
      c = vtl_cell_t'{CC_FRESH_DATA, 12'h080, 16'h0042, 1'b0, 16'h0308, 128'h1};
      xfer(c, 1'b1, 2'd0, got);
      wb(1'b0, A_RANGE_HDR, 32'h0, {4'h0, 12'h080, 16'h0042});
      wb(1'b1, A_HOLD, 32'h3, 32'h0);
      rxCongestion <= 1'b1;
      @(posedge mclk);
      rxCongestion <= 1'b0;
      c = vtl_cell_t'{CC_FRESH_DATA, 12'h002, 16'h1234, 1'b0, 16'h0401, 128'h0};
      xfer(c, 1'b1, 2'd0, got);
      chk(discSeen, 1);
      wb(1'b0, A_DISCARDS, 32'h0, 32'h1);
      c.info = 128'h1;
      xfer(c, 1'b1, 2'd1, ex(c, 1'b1, di, RV_SUCCESS));
      repeat (48) @(posedge mclk);
      c.info = 128'h0;
      xfer(c, 1'b1, 2'd1, ex(c, 1'b1, di, RV_SUCCESS));
      stall <= 1'b1;
      fork
         begin
            repeat (30) @(posedge mclk);
            chk(recircGrant, 1'b0);
            stall <= 1'b0;
         end
      join_none
      c = vtl_cell_t'{CC_RECIRC_CTL, 12'hABC, 16'h5A5A, 1'b1, 16'h0501, ~128'h0 >> 3};
      xfer(c, 1'b0, 2'd1, ex(c, 1'b1, c.info, 4'h0));
      c.code = CC_FRESH_CTL;
      xfer(c, 1'b1, 2'd1, ex(c, 1'b1, c.info, 4'h0));
      close_out();
   end
endmodule
`default_nettype wire
